/* tws_consts.vh */
// constants for the time window scheduler
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH
`define TWS_ADDR_CTRL 12'h000
`define TWS_ADDR_STAT 12'h004
`define TWS_ADDR_CH_BASE 12'h010
`define TWS_ADDR_CH_STRIDE 12'h010
`define TWS_OFF_TIME_ON 4'h0
`define TWS_OFF_TIME_OFF 4'h4
`define TWS_OFF_DATE_ON 4'h8
`define TWS_OFF_DATE_OFF 4'hc
`define TWS_TIME_RST 17'h00000
`define TWS_DATE_RST 21'h0fa000
`define TWS_WDAY_RST 7'h7f
`define TWS_CTRL_EN_BIT 0
`define TWS_WDAY_LSB 24
`endif

/* tws_top.v */
// time window scheduler with two calendar channels and ahb-lite registers
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_top (
  input wire ref_clk,
  input wire rst_n,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire rtc_present,
  input wire [4:0] rtc_hour,
  input wire [5:0] rtc_min,
  input wire [5:0] rtc_sec,
  input wire [2:0] rtc_wday,
  input wire [11:0] rtc_year,
  input wire [3:0] rtc_month,
  input wire [4:0] rtc_day,
  output reg [1:0] sched_out
);
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_l = rst_s2_q;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // rtc inputs come from another domain: two flops each
  reg [41:0] rtc_s1_q;
  reg [41:0] rtc_s2_q;
  always @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      rtc_s1_q <= 42'h0;
      rtc_s2_q <= 42'h0;
    end
    else
    begin
      rtc_s1_q <= {rtc_present, rtc_hour, rtc_min, rtc_sec, rtc_wday, rtc_year,
        rtc_month, rtc_day};
      rtc_s2_q <= rtc_s1_q;
    end
  end

  // word taken only when two synced samples agree, so a torn update is never used
  reg [41:0] rtc_s3_q;
  reg [41:0] now_q;
  always @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      rtc_s3_q <= 42'h0;
      now_q <= 42'h0;
    end
    else
    begin
      rtc_s3_q <= rtc_s2_q;
      if (rtc_s3_q == rtc_s2_q)
        now_q <= rtc_s2_q;
    end
  end
  wire present = now_q[41];
  wire [16:0] now_time = now_q[40:24];
  wire [2:0] now_wday = now_q[23:21];
  wire [20:0] now_date = now_q[20:0];

  // ahb-lite address phase capture
  reg wr_pend_q;
  reg [11:0] addr_q;
  wire take = hsel && htrans[1] && hready;
  always @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      if (hready)
      begin
        wr_pend_q <= take && hwrite;
        addr_q <= haddr;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  reg enable_q;
  reg [16:0] ton_q [0:1];
  reg [16:0] toff_q [0:1];
  reg [20:0] don_q [0:1];
  reg [20:0] doff_q [0:1];
  reg [6:0] wmask_q [0:1];
  reg [1:0] prev_hit_on_q;
  reg [1:0] prev_hit_off_q;
  reg [1:0] act_q;
  wire [1:0] ch_rd_sel;
  wire [63:0] ch_rd_flat;

  always @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
      enable_q <= 1'b1;
    else if (wr_pend_q && addr_q == `TWS_ADDR_CTRL)
      enable_q <= hwdata[`TWS_CTRL_EN_BIT];
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_ch
      wire [31:0] base = `TWS_ADDR_CH_BASE + i * `TWS_ADDR_CH_STRIDE;
      wire sel = wr_pend_q && addr_q[11:4] == base[11:4];
      wire hit_on = now_time == ton_q[i];
      wire hit_off = now_time == toff_q[i];
      wire [6:0] wbit = 7'h01 << now_wday;
      wire day_ok = |(wbit & wmask_q[i]);
      wire date_ok = now_date >= don_q[i];
      wire date_end = (doff_q[i] >= don_q[i]) && (now_date >= doff_q[i]);
      reg [31:0] rd_word;
      assign ch_rd_sel[i] = haddr[11:4] == base[11:4];
      assign ch_rd_flat[i*32 +: 32] = rd_word;
      always @*
      begin
        rd_word = 32'h0;
        case (haddr[3:0])
          `TWS_OFF_TIME_ON: rd_word = {1'b0, wmask_q[i], 7'h0, ton_q[i]};
          `TWS_OFF_TIME_OFF: rd_word = {15'h0, toff_q[i]};
          `TWS_OFF_DATE_ON: rd_word = {11'h0, don_q[i]};
          `TWS_OFF_DATE_OFF: rd_word = {11'h0, doff_q[i]};
          default: rd_word = 32'h0;
        endcase
      end
      always @(posedge ref_clk or negedge rst_l)
      begin
        if (!rst_l)
        begin
          ton_q[i] <= `TWS_TIME_RST;
          toff_q[i] <= `TWS_TIME_RST;
          don_q[i] <= `TWS_DATE_RST;
          doff_q[i] <= `TWS_DATE_RST;
          wmask_q[i] <= `TWS_WDAY_RST;
          prev_hit_on_q[i] <= 1'b0;
          prev_hit_off_q[i] <= 1'b0;
          act_q[i] <= 1'b0;
        end
        else
        begin
          if (sel && addr_q[3:0] == `TWS_OFF_TIME_ON)
          begin
            ton_q[i] <= hwdata[16:0];
            wmask_q[i] <= hwdata[`TWS_WDAY_LSB+6:`TWS_WDAY_LSB];
          end
          if (sel && addr_q[3:0] == `TWS_OFF_TIME_OFF)
            toff_q[i] <= hwdata[16:0];
          if (sel && addr_q[3:0] == `TWS_OFF_DATE_ON)
            don_q[i] <= hwdata[20:0];
          if (sel && addr_q[3:0] == `TWS_OFF_DATE_OFF)
            doff_q[i] <= hwdata[20:0];
          prev_hit_on_q[i] <= hit_on;
          prev_hit_off_q[i] <= hit_off;
          if (!present || !enable_q)
            act_q[i] <= 1'b0;
          else if (date_end)
            act_q[i] <= 1'b0;
          else if (hit_off && !prev_hit_off_q[i])
            act_q[i] <= 1'b0;
          else if (hit_on && !prev_hit_on_q[i] && date_ok && day_ok)
            act_q[i] <= 1'b1;
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
      sched_out <= 2'h0;
    else
      sched_out <= act_q;
  end

  reg [31:0] rd_d;
  always @*
  begin
    rd_d = 32'h0;
    case (haddr)
      `TWS_ADDR_CTRL: rd_d = {31'h0, enable_q};
      `TWS_ADDR_STAT: rd_d = {29'h0, present, act_q};
      default:
      begin
        if (ch_rd_sel[0])
          rd_d = ch_rd_flat[31:0];
        if (ch_rd_sel[1])
          rd_d = ch_rd_flat[63:32];
      end
    endcase
  end
  always @(posedge ref_clk or negedge rst_l)
  begin
    if (!rst_l)
      hrdata <= 32'h0;
    else if (take && !hwrite)
      hrdata <= rd_d;
  end
endmodule

/* tws_rtc_model.sv */
// real time clock source model feeding the scheduler
`timescale 1ns/1ps
module tws_rtc_model (
  input wire ref_clk,
  output reg rtc_present,
  output reg [4:0] rtc_hour,
  output reg [5:0] rtc_min,
  output reg [5:0] rtc_sec,
  output reg [2:0] rtc_wday,
  output reg [11:0] rtc_year,
  output reg [3:0] rtc_month,
  output reg [4:0] rtc_day
);
  initial {rtc_present, rtc_hour, rtc_min, rtc_sec, rtc_wday, rtc_year, rtc_month,
    rtc_day} = 42'h0;
  // time, weekday and date land together
  task put(input p, input [16:0] t, input [2:0] w, input [20:0] d);
  begin
    @(posedge ref_clk);
    rtc_present <= p;
    {rtc_hour, rtc_min, rtc_sec} <= t;
    rtc_wday <= w;
    {rtc_year, rtc_month, rtc_day} <= d;
  end
  endtask
endmodule

/* tws_top_monitor.sv */
// assertions and covers on the scheduler top ports
`timescale 1ns/1ps
module tws_top_monitor (
  input wire ref_clk,
  input wire rst_n,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire rtc_present,
  input wire [1:0] sched_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ready_high: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_out_reset: assert property ($rose(rst_n) |-> sched_out == 2'h0) else $error("out at reset");
  a_absent_low: assert property (!rtc_present [*8] |-> sched_out == 2'h0) else $error("no clock");
  a_absent_rise: assert property (!rtc_present [*8] |=> !$rose(sched_out[1])) else $error("rise");
  a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  c_out_one: cover property ($rose(sched_out[0]));
  c_out_two: cover property ($rose(sched_out[1]));
  c_clock_lost: cover property ($fell(rtc_present));
endmodule
bind tws_top tws_top_monitor i_tws_top_monitor (.*);

/* tb.sv */
// self-checking bench for the time window scheduler
`timescale 1ns/1ps
module tb;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg [11:0] haddr = 12'h000;
  reg [1:0] htrans = 2'h0;
  reg [31:0] hwdata = 32'h0;
  reg [31:0] rd_q;
  wire [2:0] hsize = 3'h2;
  wire [31:0] hrdata;
  wire hreadyout, hresp, rtc_present;
  wire hready = hreadyout;
  wire [4:0] rtc_hour, rtc_day;
  wire [5:0] rtc_min, rtc_sec;
  wire [2:0] rtc_wday;
  wire [11:0] rtc_year;
  wire [3:0] rtc_month;
  wire [1:0] sched_out;
  localparam [20:0] today = {12'h7e9, 4'h3, 5'h03};
  localparam [20:0] early = {12'h7df, 4'h3, 5'h03};
  localparam [20:0] late = {12'h833, 4'hc, 5'h1f};
  integer fails = 0;
  integer checks = 0;
  always #20 ref_clk = ~ref_clk;
  tws_top i_tws_top (.*);
  tws_rtc_model i_tws_rtc_model (.*);
  task chk(input string n, input [31:0] e, input [31:0] s);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      fails = fails + 1;
      $display("CHECK FAILED %0s expected %h seen %h", n, e, s);
    end
  end
  endtask
  task b(input w, input [11:0] a, input [31:0] d);
  begin
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd_q = hrdata;
  end
  endtask
  task rd(input [11:0] a, input [31:0] e);
  begin
    b(1'b0, a, 32'h0);
    chk("read", e, rd_q);
  end
  endtask
  task out(input [16:0] t, input [2:0] w, input [20:0] d, input p, input [1:0] e);
  begin
    i_tws_rtc_model.put(p, t, w, d);
    repeat (8) @(posedge ref_clk);
    chk("sched_out", {30'h0, e}, {30'h0, sched_out});
  end
  endtask
  task complete_run;
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    fails = fails + 1;
    complete_run;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(12'h010, 32'h7f000000);
    rd(12'h01c, 32'h000fa000);
    rd(12'h0fc, 32'h0);
    b(1'b1, 12'h010, 32'h1f008000);
    b(1'b1, 12'h014, 32'h00011000);
    b(1'b1, 12'h018, {12'h7e1, 4'h2, 5'h01});
    b(1'b1, 12'h01c, {12'h833, 4'hc, 5'h1f});
    b(1'b1, 12'h020, 32'h40008000);
    b(1'b1, 12'h024, 32'h00011000);
    b(1'b1, 12'h028, {12'h7e1, 4'h2, 5'h01});
    rd(12'h014, 32'h00011000);
    rd(12'h020, 32'h40008000);
    out(17'h07efb, 3'h0, today, 1'b1, 2'h0);
    out(17'h08000, 3'h0, today, 1'b1, 2'h1);
    out(17'h11000, 3'h0, today, 1'b1, 2'h0);
    out(17'h08000, 3'h6, today, 1'b1, 2'h2);
    out(17'h08000, 3'h6, today, 1'b0, 2'h0);
    out(17'h11000, 3'h0, early, 1'b1, 2'h0);
    out(17'h08000, 3'h0, early, 1'b1, 2'h0);
    out(17'h07efb, 3'h0, today, 1'b1, 2'h0);
    out(17'h08000, 3'h0, today, 1'b1, 2'h1);
    rd(12'h004, 32'h00000005);
    b(1'b1, 12'h000, 32'h0);
    out(17'h08000, 3'h0, today, 1'b1, 2'h0);
    rd(12'h000, 32'h0);
    b(1'b1, 12'h000, 32'h1);
    out(17'h07efb, 3'h0, today, 1'b1, 2'h0);
    out(17'h08000, 3'h0, today, 1'b1, 2'h1);
    out(17'h08000, 3'h0, late, 1'b1, 2'h0);
    complete_run;
  end
endmodule
